// *** pkg/ulpi_upper_pkg.sv ***
// package: upper ulpi register map constants and access types
package ulpi_upper_pkg;
    localparam logic [7:0] line_state_debug_addr     = 8'h15;
    localparam logic [7:0] scratch_write_addr        = 8'h16;
    localparam logic [7:0] scratch_set_addr          = 8'h17;
    localparam logic [7:0] scratch_clear_addr        = 8'h18;
    localparam logic [7:0] unimpl_low_addr           = 8'h19;
    localparam logic [7:0] unimpl_high_addr          = 8'h2E;
    localparam logic [7:0] extended_escape_addr      = 8'h2F;
    localparam logic [7:0] vendor_low_addr           = 8'h30;
    localparam logic [7:0] vendor_high_addr          = 8'h3F;
    localparam logic [7:0] power_write_addr          = 8'h3D;
    localparam logic [7:0] power_set_addr            = 8'h3E;
    localparam logic [7:0] power_clear_addr          = 8'h3F;
    localparam logic [7:0] immediate_mask            = 8'h3F;
    localparam logic [7:0] extended_last_alias       = 8'h3F;
    localparam logic [7:0] scratch_reset             = 8'h00;
    localparam logic [7:0] power_reset               = 8'h00;
    localparam int         bvalid_fall_bit           = 3;
    localparam int         bvalid_rise_bit           = 2;
    localparam int         line_level_high_pos       = 1;
    localparam int         line_level_low_pos        = 0;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       extended;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } reg_reply_t;
endpackage

// *** verilog/edge_sync.sv ***
// two-stage synchroniser with registered edge detect
`timescale 1ns/10ps
module edge_sync #(
    parameter int width = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] level_out,
    output logic      [width-1:0] rise_out,
    output logic      [width-1:0] fall_out
);
    logic [width-1:0] meta_reg;
    logic [width-1:0] sync_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level_out <= '0;
            rise_out  <= '0;
            fall_out  <= '0;
        end else begin
            level_out <= sync_reg;
            rise_out  <= sync_reg & ~level_out;
            fall_out  <= ~sync_reg & level_out;
        end
    end
endmodule

// *** verilog/ulpi_phy_upper_register_map.sv ***
// upper ulpi register bank: debug, scratch, power control, rx events
`timescale 1ns/10ps

module ulpi_phy_upper_register_map (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire ulpi_upper_pkg::reg_access_t access_in,
    input  wire logic [1:0]                 line_state_in,
    input  wire logic                       b_session_valid_in,
    input  wire logic                       rx_cmd_ack,
    output ulpi_upper_pkg::reg_reply_t      reply_out,
    output logic [7:0]                      scratch_out,
    output logic [7:0]                      power_control_out,
    output logic                            rx_cmd_req,
    output logic                            alternate_interrupt_flag
);
    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic [2:0] sync_level;
    logic [2:0] sync_rise;
    logic [2:0] sync_fall;

    edge_sync #(.width(3)) u_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .async_in  ({b_session_valid_in, line_state_in}),
        .level_out (sync_level),
        .rise_out  (sync_rise),
        .fall_out  (sync_fall)
    );

    logic line_level_bit_high;
    logic line_level_bit_low;
    assign line_level_bit_high = sync_level[1];
    assign line_level_bit_low  = sync_level[0];

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // extended accesses above 3fh decode to ffh: writes are dropped and reads return zero
    function automatic logic [7:0] map_addr(input logic       ext,
                                            input logic [7:0] a);
        if (ext && a > ulpi_upper_pkg::extended_last_alias) begin
            map_addr = 8'hFF;
        end else begin
            map_addr = a & ulpi_upper_pkg::immediate_mask;
        end
    endfunction

    function automatic logic [7:0] apply_op(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic [1:0] op);
        case (op)
            2'h0:    apply_op = wd;
            2'h1:    apply_op = cur | wd;
            2'h2:    apply_op = cur & ~wd;
            default: apply_op = cur;
        endcase
    endfunction

    logic [7:0] eff_addr;
    logic       wr_valid;
    logic       rd_valid;
    assign eff_addr = map_addr(access_in.extended, access_in.addr);
    assign wr_valid = access_in.valid & access_in.write;
    assign rd_valid = access_in.valid & ~access_in.write;

    // ----------------------------------------------------------------
    // scratch byte
    // ----------------------------------------------------------------
    logic [7:0] scratch_reg;
    logic [7:0] scratch_next;

    always_comb begin
        scratch_next = scratch_reg;
        if (wr_valid) begin
            case (eff_addr)
                ulpi_upper_pkg::scratch_write_addr:
                    scratch_next = apply_op(scratch_reg, access_in.wdata,
                                            2'h0);
                ulpi_upper_pkg::scratch_set_addr:
                    scratch_next = apply_op(scratch_reg, access_in.wdata,
                                            2'h1);
                ulpi_upper_pkg::scratch_clear_addr:
                    scratch_next = apply_op(scratch_reg, access_in.wdata,
                                            2'h2);
                default:
                    scratch_next = scratch_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scratch_reg <= ulpi_upper_pkg::scratch_reset;
        end else begin
            scratch_reg <= scratch_next;
        end
    end

    // ----------------------------------------------------------------
    // power control
    // ----------------------------------------------------------------
    logic [7:0] power_reg;
    logic [7:0] power_next;

    always_comb begin
        power_next = power_reg;
        if (wr_valid) begin
            case (eff_addr)
                ulpi_upper_pkg::power_write_addr:
                    power_next = apply_op(power_reg, access_in.wdata, 2'h0);
                ulpi_upper_pkg::power_set_addr:
                    power_next = apply_op(power_reg, access_in.wdata, 2'h1);
                ulpi_upper_pkg::power_clear_addr:
                    power_next = apply_op(power_reg, access_in.wdata, 2'h2);
                default:
                    power_next = power_reg;
            endcase
        end
    end

    // reserved bits are stored as written; the link keeps them zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_reg <= ulpi_upper_pkg::power_reset;
        end else begin
            power_reg <= power_next;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        case (eff_addr)
            ulpi_upper_pkg::line_state_debug_addr: begin
                rdata_next[ulpi_upper_pkg::line_level_high_pos] =
                    line_level_bit_high;
                rdata_next[ulpi_upper_pkg::line_level_low_pos] =
                    line_level_bit_low;
            end
            ulpi_upper_pkg::scratch_write_addr,
            ulpi_upper_pkg::scratch_set_addr,
            ulpi_upper_pkg::scratch_clear_addr:
                rdata_next = scratch_reg;
            ulpi_upper_pkg::power_write_addr,
            ulpi_upper_pkg::power_set_addr,
            ulpi_upper_pkg::power_clear_addr:
                rdata_next = power_reg;
            default:
                rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reply_out <= '0;
        end else begin
            reply_out.valid <= rd_valid;
            reply_out.rdata <= rd_valid ? rdata_next : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scratch_out       <= 8'h00;
            power_control_out <= 8'h00;
        end else begin
            scratch_out       <= scratch_reg;
            power_control_out <= power_reg;
        end
    end

    // ----------------------------------------------------------------
    // session edge rx commands
    // ----------------------------------------------------------------
    logic edge_hit;
    assign edge_hit =
        (sync_fall[2] & power_reg[ulpi_upper_pkg::bvalid_fall_bit]) |
        (sync_rise[2] & power_reg[ulpi_upper_pkg::bvalid_rise_bit]);

    // a new edge wins over the ack in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_cmd_req               <= 1'b0;
            alternate_interrupt_flag <= 1'b0;
        end else if (edge_hit) begin
            rx_cmd_req               <= 1'b1;
            alternate_interrupt_flag <= 1'b1;
        end else if (rx_cmd_ack) begin
            rx_cmd_req               <= 1'b0;
            alternate_interrupt_flag <= 1'b0;
        end
    end
endmodule

// *** bench/ulpi_upper_props.sv ***
// assertion checker for the upper register map ports
`timescale 1ns/10ps
module ulpi_upper_props (
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire ulpi_upper_pkg::reg_access_t access_in,
    input wire logic [1:0]                  line_state_in,
    input wire logic                        b_session_valid_in,
    input wire logic                        rx_cmd_ack,
    input wire ulpi_upper_pkg::reg_reply_t  reply_out,
    input wire logic [7:0]                  scratch_out,
    input wire logic [7:0]                  power_control_out,
    input wire logic                        rx_cmd_req,
    input wire logic                        alternate_interrupt_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic       rd;
    logic       wr;
    logic [7:0] a;
    logic [7:0] q;
    assign rd = access_in.valid && !access_in.write;
    assign wr = access_in.valid && access_in.write;
    assign a  = access_in.addr;
    assign q  = reply_out.rdata;
    sequence s_pset;
        wr && a == 8'h3E ##1 !access_in.valid;
    endsequence
    sequence s_pclr;
        wr && a == 8'h3F ##1 !access_in.valid;
    endsequence
    AST_READ_REPLY: assert property (rd |=> reply_out.valid)
        else $error("read without reply");
    AST_DEBUG_HIGH_ZERO: assert property (
        rd && a == 8'h15 |=> q[7:2] == 6'h00)
        else $error("debug upper bits not zero");
    AST_UNIMPL_READ: assert property (
        rd && a inside {[8'h19:8'h2F]} |=> q == 8'h00)
        else $error("unimplemented read not zero");
    AST_VENDOR_READ: assert property (
        rd && a inside {[8'h30:8'h3C]} |=> q == 8'h00)
        else $error("vendor gap read not zero");
    AST_SCRATCH_WRITE: assert property (wr && a == 8'h16
        |-> ##2 scratch_out == $past(access_in.wdata, 2))
        else $error("scratch write lost");
    AST_POWER_SET: assert property (s_pset |=> power_control_out ==
        ($past(power_control_out) | $past(access_in.wdata, 2)))
        else $error("power set wrong");
    AST_POWER_CLEAR: assert property (s_pclr |=> power_control_out ==
        ($past(power_control_out) & ~$past(access_in.wdata, 2)))
        else $error("power clear wrong");
    AST_ALT_MIRROR: assert property (
        alternate_interrupt_flag == rx_cmd_req)
        else $error("alt flag differs from request");
    AST_REQ_HOLD: assert property (
        rx_cmd_req && !rx_cmd_ack |=> rx_cmd_req)
        else $error("request dropped before ack");
    AST_REQ_CAUSE: assert property (
        $rose(rx_cmd_req) |-> power_control_out[3:2] != 2'h0)
        else $error("request with edges disabled");
endmodule
bind ulpi_phy_upper_register_map ulpi_upper_props u_ulpi_upper_props (
    .sys_clk, .rst, .access_in, .line_state_in, .b_session_valid_in,
    .rx_cmd_ack, .reply_out, .scratch_out, .power_control_out, .rx_cmd_req,
    .alternate_interrupt_flag);

// *** bench/link_ack_model.sv ***
// link-side model accepting receive commands after a chosen delay
`timescale 1ns/10ps
module link_ack_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       rx_cmd_req,
    input  wire logic       alternate_interrupt_flag,
    input  wire logic [3:0] ack_delay,
    output logic            rx_cmd_ack,
    output int              alt_count
);
    logic [3:0] wait_reg;
    // edge commands only counted, session state read elsewhere
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
            rx_cmd_ack <= 1'b0;
            alt_count <= 0;
        end else if (rx_cmd_ack) begin
            rx_cmd_ack <= 1'b0;
            wait_reg <= 4'h0;
        end else if (rx_cmd_req && wait_reg == ack_delay) begin
            rx_cmd_ack <= 1'b1;
            alt_count <= alt_count + int'(alternate_interrupt_flag);
        end else if (rx_cmd_req) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

// *** bench/tb_ulpi_phy_upper_register_map.sv ***
// self-checking bench for the upper register map
`timescale 1ns/10ps
`define CHECK_EQ(g, e) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_ulpi_phy_upper_register_map;
    typedef struct packed {
        logic w; logic x; logic [7:0] a; logic [7:0] d; logic [7:0] e;
    } row_t;
    logic                        sys_clk = 1'b0;
    logic                        rst = 1'b1;
    ulpi_upper_pkg::reg_access_t access_in = '0;
    logic [1:0]                  line_state_in = 2'h0;
    logic                        b_session_valid_in = 1'b0;
    logic [3:0]                  ack_delay = 4'h0;
    logic                        rx_cmd_ack;
    ulpi_upper_pkg::reg_reply_t  reply_out;
    logic [7:0]                  scratch_out;
    logic [7:0]                  power_control_out;
    logic                        rx_cmd_req;
    logic                        alternate_interrupt_flag;
    logic [7:0]                  rd;
    int                          alt_count;
    int                          num_errors = 0;
    int                          comparisons = 0;
    row_t rows[25] = '{
        '{0,0,8'h16,8'h00,8'h00}, '{0,0,8'h3D,8'h00,8'h00},
        '{1,0,8'h16,8'hA5,8'h00}, '{0,0,8'h16,8'h00,8'hA5},
        '{1,0,8'h17,8'h0F,8'h00}, '{0,0,8'h16,8'h00,8'hAF},
        '{1,0,8'h18,8'hA0,8'h00}, '{0,0,8'h16,8'h00,8'h0F},
        '{1,0,8'h3D,8'h0C,8'h00}, '{0,0,8'h3D,8'h00,8'h0C},
        '{1,0,8'h3F,8'h08,8'h00}, '{0,0,8'h3D,8'h00,8'h04},
        '{1,0,8'h3E,8'h08,8'h00}, '{0,0,8'h3D,8'h00,8'h0C},
        '{1,0,8'h20,8'hFF,8'h00}, '{0,0,8'h20,8'h00,8'h00},
        '{1,0,8'h2F,8'hFF,8'h00}, '{0,0,8'h2F,8'h00,8'h00},
        '{1,0,8'h30,8'hFF,8'h00}, '{0,0,8'h30,8'h00,8'h00},
        '{0,0,8'h16,8'h00,8'h0F}, '{0,0,8'h3D,8'h00,8'h0C},
        '{1,1,8'h16,8'h5A,8'h00}, '{0,0,8'h16,8'h00,8'h5A},
        '{0,1,8'h3D,8'h00,8'h0C}};
    always #50 sys_clk = ~sys_clk;
    ulpi_phy_upper_register_map u_ulpi_phy_upper_register_map (
        .sys_clk, .rst, .access_in, .line_state_in, .b_session_valid_in,
        .rx_cmd_ack, .reply_out, .scratch_out, .power_control_out,
        .rx_cmd_req, .alternate_interrupt_flag);
    link_ack_model u_link_ack_model (.sys_clk, .rst, .rx_cmd_req,
        .alternate_interrupt_flag, .ack_delay, .rx_cmd_ack, .alt_count);
    task automatic acc(input logic w, x, input logic [7:0] a, d,
                       output logic [7:0] r);
        @(posedge sys_clk);
        access_in <= '{1'b1, w, x, a, d};
        @(posedge sys_clk);
        access_in <= '0;
        #1;
        if (!reply_out.valid) begin
            @(posedge sys_clk);
            #1;
        end
        r = reply_out.rdata;
    endtask
    // session edge, then a bounded wait for the command and its release
    task automatic sess(input logic lvl, input logic exp_req);
        @(posedge sys_clk);
        b_session_valid_in <= lvl;
        for (int i = 0; i < 10 && !rx_cmd_req; i++) @(posedge sys_clk);
        `CHECK_EQ(rx_cmd_req, exp_req)
        for (int i = 0; i < 20 && rx_cmd_req; i++) @(posedge sys_clk);
        $display("TB: session edge %0d done", lvl);
    endtask
    task automatic final_report;
        $display("TB: %0d comparisons, %0d errors", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        `CHECK_EQ(scratch_out, 8'h00)
        `CHECK_EQ(power_control_out, 8'h00)
        foreach (rows[k]) begin
            acc(rows[k].w, rows[k].x, rows[k].a, rows[k].d, rd);
            if (!rows[k].w) `CHECK_EQ(rd, rows[k].e)
        end
        $display("TB: register rows done");
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            line_state_in <= 2'(k);
            repeat (4) @(posedge sys_clk);
            acc(1'b0, 1'b0, 8'h15, 8'h00, rd);
            `CHECK_EQ(rd, {6'h00, 2'(k)})
        end
        $display("TB: line state done");
        sess(1'b1, 1'b1);
        ack_delay <= 4'h5;
        sess(1'b0, 1'b1);
        acc(1'b1, 1'b0, 8'h16, 8'hFF, rd);
        acc(1'b1, 1'b0, 8'h3F, 8'h0C, rd);
        sess(1'b1, 1'b0);
        sess(1'b0, 1'b0);
        `CHECK_EQ(alt_count, 2)
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHECK_EQ(scratch_out, 8'h00)
        `CHECK_EQ(power_control_out, 8'h00)
        rst <= 1'b0;
        acc(1'b1, 1'b0, 8'h16, 8'h3C, rd);
        `CHECK_EQ(scratch_out, 8'h3C)
        acc(1'b1, 1'b0, 8'h3E, 8'h04, rd);
        `CHECK_EQ(power_control_out, 8'h04)
        acc(1'b0, 1'b0, 8'h16, 8'h00, rd);
        `CHECK_EQ(rd, 8'h3C)
        $display("TB: mid-run reset done");
        final_report;
    end
endmodule
